// >>> core/crlp_defs.svh
// Constants for the core reset and low-power control block
`ifndef CRLP_DEFS_SVH
`define CRLP_DEFS_SVH
`define CRLP_RESET_PULSE_CYCLES 6
`define CRLP_STATUS_EXL_POS 1
`define CRLP_STATUS_ERL_POS 2
`define CRLP_STATUS_SR_POS 20
`define CRLP_DEBUG_DM_POS 30
`define CRLP_NUM_HW_INT 8
`define CRLP_CNT_W 3
`endif

// >>> core/crlp_pkg.sv
// Types for the core reset and low-power control block
package crlp_pkg;
  typedef enum logic [1:0] {
    CRLP_ST_RESET,
    CRLP_ST_RUN,
    CRLP_ST_IDLE
  } crlp_state_t;
endpackage : crlp_pkg

// >>> core/crlp_sync2.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module crlp_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : crlp_sync2

// >>> core/crlp_ctrl.sv
// Reset sequencing, power-state mirroring and idle-mode control for the core
// What this block does
// R1: Two active-low resets, warm and cold, sync or async, each cause a reset.
// R2: A reset request yields a six-cycle internal reset pulse, then clean synchronous exit.
// R3: Warm reset lets the debug boot request enter debug mode at reset end.
// R4: Cold reset ignores debug boot and starts fetching in kernel mode.
// R5: Warm reset sets the soft-reset flag so software can tell them apart.
// R6: Both reset inputs high means normal operation and no reset action.
// R7: System logic asserts a reset input at power-on and when reinitialisation is wanted.
// R8: Exception-level output follows status bit 1 as it sets and clears.
// R9: Error-level output follows status bit 2 as it sets and clears.
// R10: Debug-mode output follows debug register bit 30.
// R11: External power logic may watch those three outputs to decide on waking.
// R12: Idle stops the internal clock; timer, interrupts, NMI and resets keep running.
// R13: Any interrupt, NMI or reset ends idle mode and resumes operation.
// R14: Sleep indicator rises when the idle instruction executes.
// R15: State holds correctly when the clock is slowed or halted.
// R16: Sleep indicator falls once a wake-up restarts the clock and execution.
`timescale 1ns/1ps
`include "crlp_defs.svh"
module crlp_ctrl #(
  parameter int RESET_CYCLES = `CRLP_RESET_PULSE_CYCLES,
  parameter int NUM_INT = `CRLP_NUM_HW_INT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic warm_reset_n_in,
  input wire logic cold_reset_n_in,
  input wire logic debug_boot_request,
  input wire logic [NUM_INT-1:0] hw_int_in,
  input wire logic nmi_in,
  input wire logic timer_int,
  input wire logic idle_exec,
  input wire logic [31:0] status_in,
  input wire logic [31:0] debug_in,
  output logic core_reset,
  output logic reset_done,
  output logic warm_reset_taken,
  output logic soft_reset_flag,
  output logic debug_boot_enter,
  output logic kernel_boot,
  output logic core_clock_enable,
  output logic sleep_out,
  output logic exception_level_out,
  output logic error_level_out,
  output logic debug_mode_out
);
  localparam int CW = `CRLP_CNT_W;
  localparam logic [CW-1:0] LAST_CNT = CW'(RESET_CYCLES - 1);
  localparam int MIRROR_W = 3;

  logic warm_n_sync;
  logic cold_n_sync;
  logic nmi_sync;
  logic [NUM_INT-1:0] int_sync;
  crlp_pkg::crlp_state_t state_reg;
  logic [CW-1:0] cnt_reg;
  logic warm_src_reg;
  logic dbg_req_reg;
  logic reset_req;
  logic wake;
  logic in_reset;
  logic seq_exit;
  logic debug_boot_ok;
  logic idle_enter;
  logic idle_hold;
  logic sleep_next;
  logic [MIRROR_W-1:0] mirror_src;
  logic [MIRROR_W-1:0] mirror_q;

  // Synchroniser clears to zero, so both pins read as asserted until seen high
  crlp_sync2 #(.WIDTH(2), .RESET_VAL(2'h0)) u_rst_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({warm_reset_n_in, cold_reset_n_in}),
    .q({warm_n_sync, cold_n_sync})
  );

  crlp_sync2 #(.WIDTH(NUM_INT + 2), .RESET_VAL('0)) u_wake_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({hw_int_in, nmi_in, debug_boot_request}),
    .q({int_sync, nmi_sync, dbg_req_reg})
  );

  assign reset_req = !warm_n_sync || !cold_n_sync; // R1 R6
  assign wake = (|int_sync) || nmi_sync || timer_int || reset_req; // R13

  // Decoded sequencer events, shared by the state, boot and sleep logic
  assign in_reset = (state_reg == crlp_pkg::CRLP_ST_RESET);
  assign seq_exit = in_reset && (cnt_reg == LAST_CNT) && !reset_req; // R2
  assign debug_boot_ok = warm_src_reg && dbg_req_reg; // R3
  // Reset beats idle, so an idle pulse that meets a reset request is dropped
  assign idle_enter = (state_reg == crlp_pkg::CRLP_ST_RUN) && idle_exec && !reset_req; // R14
  assign idle_hold = (state_reg == crlp_pkg::CRLP_ST_IDLE) && !wake; // R13
  assign sleep_next = idle_enter || idle_hold;

  // Sequencer; this logic sits on the free-running clock so it sees wakes
  // while the gated core clock is stopped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= crlp_pkg::CRLP_ST_RESET;
    end else if (reset_req) begin
      state_reg <= crlp_pkg::CRLP_ST_RESET; // R1
    end else begin
      unique case (state_reg)
        crlp_pkg::CRLP_ST_RESET: begin
          if (cnt_reg == LAST_CNT) begin
            state_reg <= crlp_pkg::CRLP_ST_RUN; // R2
          end
        end
        crlp_pkg::CRLP_ST_RUN: begin
          if (idle_enter) begin
            state_reg <= crlp_pkg::CRLP_ST_IDLE; // R12 R14
          end
        end
        crlp_pkg::CRLP_ST_IDLE: begin
          if (wake) begin
            state_reg <= crlp_pkg::CRLP_ST_RUN; // R13 R16
          end
        end
        default: begin
          state_reg <= crlp_pkg::CRLP_ST_RESET;
        end
      endcase
    end
  end

  // Pulse timer; cleared outside reset so every entry into reset times a full pulse,
  // even one reached from an illegal state code
  always_ff @(posedge ref_clk) begin
    if (rst || reset_req) begin
      cnt_reg <= '0; // R1
    end else if (!in_reset) begin
      cnt_reg <= '0;
    end else if (cnt_reg != LAST_CNT) begin
      cnt_reg <= cnt_reg + CW'(1); // R2
    end
  end

  // Remember which pin started the reset; cold wins if both are low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warm_src_reg <= 1'b0;
    end else if (!cold_n_sync) begin
      warm_src_reg <= 1'b0; // R4
    end else if (!warm_n_sync) begin
      warm_src_reg <= 1'b1; // R5
    end
  end

  // The core leaves reset on the same edge as the exit pulse rises
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= (in_reset && !seq_exit) || reset_req; // R2
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reset_done <= 1'b0;
    end else begin
      reset_done <= seq_exit; // R2
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      debug_boot_enter <= 1'b0;
      kernel_boot <= 1'b0;
    end else begin
      debug_boot_enter <= seq_exit && debug_boot_ok; // R3
      kernel_boot <= seq_exit && !debug_boot_ok; // R4
    end
  end

  // Updated only while in reset, so software reads a steady value afterwards
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      soft_reset_flag <= 1'b0;
    end else if (in_reset) begin
      soft_reset_flag <= warm_src_reg; // R5
    end
  end

  assign warm_reset_taken = warm_src_reg;

  // Both come from one next value so they never disagree once rst is released; rst holds both low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sleep_out <= 1'b0;
    end else begin
      sleep_out <= sleep_next; // R14 R16
    end
  end

  // The clock is held off while rst is high but keeps running through the internal reset pulse so it can be timed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_clock_enable <= 1'b0;
    end else begin
      core_clock_enable <= !sleep_next; // R12 R15
    end
  end

  // Mirror sources in output order: exception level, error level, debug mode
  assign mirror_src = {
    status_in[`CRLP_STATUS_EXL_POS], // R8
    status_in[`CRLP_STATUS_ERL_POS], // R9
    debug_in[`CRLP_DEBUG_DM_POS] // R10
  };

  for (genvar b = 0; b < MIRROR_W; b++) begin : g_mirror
    logic hold_reg;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        hold_reg <= 1'b0;
      end else begin
        hold_reg <= mirror_src[b];
      end
    end
    assign mirror_q[b] = hold_reg;
  end

  assign exception_level_out = mirror_q[2]; // R8
  assign error_level_out = mirror_q[1]; // R9
  assign debug_mode_out = mirror_q[0]; // R10
endmodule : crlp_ctrl

// >>> testbench/crlp_ctrl_monitor.sv
// Port assertions for the reset and low-power control block
`timescale 1ns/1ps
module crlp_ctrl_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic idle_exec,
  input wire logic timer_int,
  input wire logic nmi_in,
  input wire logic [31:0] status_in,
  input wire logic [31:0] debug_in,
  input wire logic core_reset,
  input wire logic reset_done,
  input wire logic core_clock_enable,
  input wire logic sleep_out,
  input wire logic exception_level_out,
  input wire logic error_level_out,
  input wire logic debug_mode_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_exl_mirror: assert property (!$past(rst) |-> exception_level_out == $past(status_in[1])) else $error("exl");
  a_erl_mirror: assert property (!$past(rst) |-> error_level_out == $past(status_in[2])) else $error("erl");
  a_dm_mirror: assert property (!$past(rst) |-> debug_mode_out == $past(debug_in[30])) else $error("dm");
  a_sleep_enter: assert property (idle_exec && !core_reset && !sleep_out ##1 !core_reset |-> sleep_out)
    else $error("slp");
  a_clock_stop: assert property (!core_reset |-> sleep_out != core_clock_enable) else $error("clk");
  a_timer_wake: assert property (sleep_out && timer_int |=> !sleep_out) else $error("tmr");
  a_nmi_wake: assert property (sleep_out && nmi_in |-> ##[1:4] !sleep_out) else $error("nmi");
  a_pulse_len: assert property (reset_done |-> $past(core_reset) && $past(core_reset, 6)) else $error("rst");
  a_reset_exit: assert property (reset_done |-> !core_reset ##1 !reset_done) else $error("exit");
  a_idle_refused: assert property (core_reset && idle_exec |=> !sleep_out) else $error("refused");
  c_done: cover property (reset_done);
  c_refused: cover property (core_reset && idle_exec);
  c_sleep: cover property ($rose(sleep_out));
  c_nmi: cover property (sleep_out && nmi_in);
endmodule : crlp_ctrl_monitor
bind crlp_ctrl crlp_ctrl_monitor i_mon (.ref_clk, .rst, .idle_exec, .timer_int, .nmi_in, .status_in, .debug_in,
  .core_reset, .reset_done, .core_clock_enable, .sleep_out, .exception_level_out, .error_level_out, .debug_mode_out);

// >>> testbench/crlp_sys_model.sv
// System-side reset source for the core reset and low-power control block
`timescale 1ns/1ps
module crlp_sys_model (
  input wire logic ref_clk,
  output logic warm_reset_n_in,
  output logic cold_reset_n_in
);
  // Cold reset is held from power-on so the core never starts uninitialised
  initial {warm_reset_n_in, cold_reset_n_in} = 2'h2;
  task automatic hit(input logic warm);
    @(posedge ref_clk);
    warm_reset_n_in <= !warm;
    cold_reset_n_in <= warm;
    repeat (3) @(posedge ref_clk);
    warm_reset_n_in <= 1'h1;
    cold_reset_n_in <= 1'h1;
  endtask : hit
endmodule : crlp_sys_model

// >>> testbench/tb_core_reset_and_low_power_control.sv
// Testbench for the core reset and low-power control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; \
  if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_core_reset_and_low_power_control;
  logic ref_clk = 1'h0, rst = 1'h1, debug_boot_request = 1'h0, nmi_in = 1'h0, timer_int = 1'h0, idle_exec = 1'h0;
  logic [7:0] hw_int_in = 8'h00;
  logic [31:0] status_in = 32'h0, debug_in = 32'h0;
  logic warm_reset_n_in, cold_reset_n_in, core_reset, reset_done, warm_reset_taken, soft_reset_flag;
  logic debug_boot_enter, kernel_boot, core_clock_enable, sleep_out;
  logic exception_level_out, error_level_out, debug_mode_out;
  int bad_count = 0, n_compared = 0, i;
  always #2.5 ref_clk = ~ref_clk;
  crlp_sys_model i_sys (.ref_clk, .warm_reset_n_in, .cold_reset_n_in);
  crlp_ctrl i_dut (.ref_clk, .rst, .warm_reset_n_in, .cold_reset_n_in, .debug_boot_request, .hw_int_in, .nmi_in,
    .timer_int, .idle_exec, .status_in, .debug_in, .core_reset, .reset_done, .warm_reset_taken, .soft_reset_flag,
    .debug_boot_enter, .kernel_boot, .core_clock_enable, .sleep_out, .exception_level_out, .error_level_out,
    .debug_mode_out);
  task automatic test_done;
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  task automatic t_boot(input logic warm, input logic dbg);
    @(posedge ref_clk) debug_boot_request <= dbg;
    i_sys.hit(warm);
    // An idle request while the core is still held in reset must be ignored
    @(posedge ref_clk) idle_exec <= 1'h1;
    @(posedge ref_clk) idle_exec <= 1'h0;
    for (i = 0; i < 40 && reset_done !== 1'h1; i++) @(negedge ref_clk);
    `CHK({i < 40, debug_boot_enter, kernel_boot}, {1'h1, warm & dbg, !(warm & dbg)})
    `CHK({soft_reset_flag, warm_reset_taken, sleep_out, core_reset}, {warm, warm, 2'h0})
    if (i == 40) test_done();
  endtask : t_boot
  task automatic t_idle(input int k);
    @(posedge ref_clk) idle_exec <= 1'h1;
    @(posedge ref_clk) idle_exec <= 1'h0;
    {status_in, debug_in} <= {status_in ^ 32'h6, ~debug_in};
    repeat (3) @(negedge ref_clk);
    `CHK({sleep_out, core_clock_enable}, 2'h2)
    `CHK({exception_level_out, error_level_out}, {status_in[1], status_in[2]})
    `CHK(debug_mode_out, debug_in[30])
    // A reset is also a wake source, so the idle core must wake straight into reset
    if (k == 3) i_sys.hit(1'h1);
    @(posedge ref_clk) {timer_int, nmi_in, hw_int_in} <= {k == 0, k == 1, 8'(k == 2) << 5};
    for (i = 0; i < 8 && sleep_out !== 1'h0; i++) @(negedge ref_clk);
    `CHK({i < 8, core_reset, core_clock_enable}, {1'h1, k == 3, 1'h1})
    if (i == 8) test_done();
    @(posedge ref_clk) {timer_int, nmi_in, hw_int_in} <= 10'h000;
    repeat (20) @(posedge ref_clk);
  endtask : t_idle
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    t_boot(1'h0, 1'h1);
    t_boot(1'h1, 1'h1);
    t_boot(1'h1, 1'h0);
    for (int k = 0; k < 4; k++) t_idle(k);
    test_done();
  end
endmodule : tb_core_reset_and_low_power_control
